// ### src/rpw_pkg.sv
// Purpose: Shared constants and types for the power, wake and RAM-clear logic
// Assumes: 125 MHz system clock, 32.768 kHz timebase made by a divider
// Notes: Register offsets are bus addresses on the multiplexed AD lines
package rpw_pkg;

	// ------------------------------------------------------------------
	// Clock and timebase
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned TB_HZ = 32768;
	// Timebase divider, truncated; the rate error is below 0.03 percent
	localparam int unsigned TB_DIV = CLK_HZ / TB_HZ;
	// Lead of the increment status bit ahead of the update, in us
	localparam int unsigned UPD_LEAD_US = 122;
	// Lead in timebase ticks, rounded up (122 us is four ticks)
	localparam int unsigned UPD_LEAD_TICKS =
		(UPD_LEAD_US * TB_HZ + 999999) / 1000000;
	// Length of the update cycle itself, in ticks
	localparam int unsigned UPD_LEN_TICKS = 8;
	// Ticks in one second
	localparam int unsigned SEC_TICKS = TB_HZ;
	// Power-on timeout, in ms, and its count of timebase ticks
	localparam int unsigned POTO_MS = 2000;
	localparam int unsigned POTO_TICKS_DEF = POTO_MS * TB_HZ / 1000;
	// Access recovery time after a clear, in us, and its cycle count
	localparam int unsigned REC_US = 200;
	localparam int unsigned REC_CYCLES_DEF = REC_US * (CLK_HZ / 1000000);

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_EXT_STAT_A = 8'h4A;
	localparam logic [7:0] OFS_EXT_CTRL_B = 8'h4B;
	localparam logic [7:0] OFS_XRAM_ADDR = 8'h50;
	localparam logic [7:0] OFS_XRAM_DATA = 8'h53;
	// Extended bank window and the first user RAM byte
	localparam logic [7:0] OFS_BANK1_LO = 8'h40;
	localparam logic [7:0] OFS_BANK1_HI = 8'h7F;
	localparam logic [7:0] OFS_URAM_LO = 8'h0E;
	localparam int unsigned URAM_BYTES = 242;
	localparam int unsigned XRAM_BYTES = 128;
	// Reset values and the RAM clear value
	localparam logic [7:0] RST_CTRL_B = 8'h00;
	localparam logic [6:0] RST_XRAM_ADDR = 7'h00;
	localparam logic [7:0] URAM_CLEAR_VAL = 8'hFF;

	// Status/control register A layout
	typedef struct packed {
		logic aux_battery_ok;
		logic update_pending;
		logic [1:0] spare;
		logic power_active_bar;
		logic ram_clear_flag;
		logic wakeup_flag;
		logic kickstart_event_flag;
	} rpw_stat_a_t;

	// Control register B layout
	typedef struct packed {
		logic aux_battery_enable;
		logic enable_32k;
		logic crystal_select;
		logic ram_clear_enable;
		logic power_fail_hold_select;
		logic ram_clear_irq_enable;
		logic wakeup_irq_enable;
		logic kickstart_irq_enable;
	} rpw_ctrl_b_t;

	// Host bus pins, sampled in the clock domain
	typedef struct packed {
		logic ale;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] ad;
	} rpw_bus_t;

	// Power sequencing states
	typedef enum logic [1:0] {
		PS_DOWN,
		PS_WAIT,
		PS_FAILED,
		PS_ON
	} rpw_pstate_t;

endpackage

// ### src/rpw_ctrl.sv
// Purpose: Power request, wake/kickstart, RAM clear and extended RAM logic
// Assumes: All pins synchronous to clock_i; supply comparators outside
// Notes: Open-drain pins are given as a value and an output enable
`timescale 1ns/10ps

module rpw_ctrl
	import rpw_pkg::*;
#(
	parameter int unsigned POTO_TICKS = POTO_TICKS_DEF,
	parameter int unsigned REC_CYCLES = REC_CYCLES_DEF
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire rpw_bus_t bus_i,
	output logic [7:0] ad_o,
	output logic ad_oe_o,
	input wire logic bank_select_i,
	input wire logic [2:0] divider_bits_i,
	input wire logic main_supply_ok_i,
	input wire logic aux_battery_supply_i,
	input wire logic alarm_match_i,
	input wire logic other_irq_i,
	input wire logic power_key_input_n_i,
	input wire logic ram_clear_input_n_i,
	output logic power_request_n_o,
	output logic power_request_n_oe_o,
	output logic irq_n_o,
	output logic irq_n_oe_o,
	output logic enable_32k_o,
	output logic crystal_select_o
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (POTO_TICKS < 1 || POTO_TICKS > 1 << 20)
	begin : g_bad_poto
		$error("POTO_TICKS out of range");
	end
	if (REC_CYCLES < URAM_BYTES || REC_CYCLES > 1 << 24)
	begin : g_bad_rec
		$error("REC_CYCLES must cover the clear walk");
	end

	// ------------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------------
	logic [7:0] uram_q [URAM_BYTES]; // User RAM
	logic [7:0] xram_q [XRAM_BYTES]; // Extended RAM
	rpw_stat_a_t stat_q; // Register A (status bits are live)
	rpw_ctrl_b_t ctrl_q; // Register B
	logic [6:0] xaddr_q; // Extended RAM pointer
	logic [7:0] addr_q; // Latched bus address
	logic wr_prev_q; // Write strobe history
	logic key_prev_q; // Key pin history
	logic clr_prev_q; // Clear pin history
	logic main_prev_q; // Supply history
	logic [11:0] div_q; // Timebase divider
	logic tick_q; // 32 kHz enable pulse
	logic [14:0] sec_q; // Ticks within the second
	logic [20:0] poto_q; // Power-on timeout counter
	logic [24:0] rec_q; // Lockout counter
	logic clearing_q; // Clear walk running
	logic [7:0] clr_idx_q; // Clear walk index
	logic upd_q; // Increment in progress
	rpw_pstate_t ps_q; // Power sequencing state
	rpw_pstate_t ps_d;
	logic [7:0] rdata_q;
	logic rd_oe_q;
	logic pwr_oe_q;
	logic irq_oe_q;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	wire locked = (rec_q != 25'd0) | clearing_q;
	wire sel = ~bus_i.cs_n;
	// Write taken on the falling edge of the write strobe
	wire wr_stb = sel & ~bus_i.wr_n & wr_prev_q & ~locked;
	wire rd_act = sel & ~bus_i.rd_n & ~locked;
	wire in_bank1 = bank_select_i & (addr_q >= OFS_BANK1_LO) &
		(addr_q <= OFS_BANK1_HI);
	wire hit_a = in_bank1 & (addr_q == OFS_EXT_STAT_A);
	wire hit_b = in_bank1 & (addr_q == OFS_EXT_CTRL_B);
	wire hit_xa = in_bank1 & (addr_q == OFS_XRAM_ADDR);
	wire hit_xd = in_bank1 & (addr_q == OFS_XRAM_DATA);
	// Calendar bytes below the user RAM are handled elsewhere
	wire hit_u = ~in_bank1 & (addr_q >= OFS_URAM_LO);
	wire [7:0] uidx = addr_q - OFS_URAM_LO;
	rpw_stat_a_t wstat;
	assign wstat = rpw_stat_a_t'(bus_i.ad);

	// ------------------------------------------------------------------
	// Events
	// ------------------------------------------------------------------
	// Battery mode needs battery, oscillator and divider 01X
	wire osc_ok = divider_bits_i[2:1] == 2'b01;
	wire battery_ok = aux_battery_supply_i & ctrl_q.aux_battery_enable &
		osc_ok;
	wire alive = main_supply_ok_i | battery_ok;
	// Alarm match and key falling edge
	wire wake_ev = alarm_match_i & alive;
	wire kick_ev = key_prev_q & ~power_key_input_n_i & alive;
	// Flags act only with their enable set
	wire wake_act = stat_q.wakeup_flag & ctrl_q.wakeup_irq_enable;
	wire kick_act = stat_q.kickstart_event_flag &
		ctrl_q.kickstart_irq_enable;
	wire start_req = (wake_ev & ctrl_q.wakeup_irq_enable) |
		(kick_ev & ctrl_q.kickstart_irq_enable);
	// Clear starts on a falling edge with enable set, flag clear
	// With the enable low the pin is ignored
	wire clr_start = clr_prev_q & ~ram_clear_input_n_i &
		ctrl_q.ram_clear_enable & ~stat_q.ram_clear_flag & ~clearing_q;
	wire clr_done = clearing_q &
		(clr_idx_q == 8'(URAM_BYTES - 1));
	wire poto_end = poto_q == 21'(POTO_TICKS - 1);

	// ------------------------------------------------------------------
	// Power sequencing
	// ------------------------------------------------------------------
	always_comb
	begin
		ps_d = ps_q;
		case (ps_q)
			PS_DOWN, PS_FAILED:
			begin
				// Power from elsewhere counts as a session too
				if (main_supply_ok_i)
					ps_d = PS_ON;
				else if (start_req)
					ps_d = PS_WAIT;
			end
			PS_WAIT:
			begin
				// Supply in time keeps the session
				if (main_supply_ok_i)
					ps_d = PS_ON;
				else if (tick_q & poto_end)
					ps_d = PS_FAILED;
			end
			PS_ON:
			begin
				if (!main_supply_ok_i)
					ps_d = PS_DOWN;
			end
			default:
				ps_d = PS_DOWN;
		endcase
	end

	// State register
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			ps_q <= PS_ON;
		else
			ps_q <= ps_d;
	end

	// Timeout counter on the timebase, restarted per attempt
	always_ff @(posedge clock_i)
	begin
		if (rst_i || ps_q != PS_WAIT)
			poto_q <= 21'd0;
		else if (tick_q)
			poto_q <= poto_q + 21'd1;
	end

	// ------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------
	// Power request: level depends on state and power-active-bar
	logic pwr_drive;
	always_comb
	begin
		case (ps_q)
			// Hold select keeps the request through power-fail
			PS_DOWN:
				pwr_drive = ~stat_q.power_active_bar &
					ctrl_q.power_fail_hold_select;
			PS_WAIT:
				pwr_drive = 1'b1;
			PS_FAILED:
				pwr_drive = 1'b0;
			// Bit directly governs the pin; auto-clear below
			PS_ON:
				pwr_drive = ~stat_q.power_active_bar;
			default:
				pwr_drive = 1'b0;
		endcase
	end

	// Interrupt sources while powered
	// Released when every source is gone
	// Clear flag interrupts only with its enable
	wire irq_src = wake_act | kick_act | other_irq_i |
		(stat_q.ram_clear_flag & ctrl_q.ram_clear_irq_enable);
	// Never driven below the power-fail threshold
	wire irq_drive = main_supply_ok_i & (ps_q == PS_ON) & irq_src;

	// Output flops; the pin value is always low, only the enable moves
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			pwr_oe_q <= 1'b0;
			irq_oe_q <= 1'b0;
		end
		else
		begin
			pwr_oe_q <= pwr_drive;
			irq_oe_q <= irq_drive;
		end
	end

	// ------------------------------------------------------------------
	// Timebase and increment status
	// ------------------------------------------------------------------
	// Divider only runs while the oscillator chain is out of reset
	always_ff @(posedge clock_i)
	begin
		if (rst_i || !osc_ok)
		begin
			div_q <= 12'd0;
			tick_q <= 1'b0;
			sec_q <= 15'd0;
		end
		else
		begin
			tick_q <= div_q == 12'(TB_DIV - 1);
			div_q <= (div_q == 12'(TB_DIV - 1)) ? 12'd0 : div_q + 12'd1;
			if (tick_q)
				sec_q <= sec_q + 15'd1;
		end
	end

	// Set ahead of the rollover, cleared when the update ends
	always_ff @(posedge clock_i)
	begin
		if (rst_i || !osc_ok)
			upd_q <= 1'b0;
		else if (tick_q && sec_q == 15'(SEC_TICKS - UPD_LEAD_TICKS - 1))
			upd_q <= 1'b1;
		else if (tick_q && sec_q == 15'(UPD_LEN_TICKS - 1))
			upd_q <= 1'b0;
	end

	// ------------------------------------------------------------------
	// History flops and latched address
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			wr_prev_q <= 1'b0;
			key_prev_q <= 1'b1;
			clr_prev_q <= 1'b1;
			main_prev_q <= 1'b0;
			addr_q <= 8'h00;
		end
		else
		begin
			wr_prev_q <= bus_i.wr_n;
			key_prev_q <= power_key_input_n_i;
			clr_prev_q <= ram_clear_input_n_i;
			main_prev_q <= main_supply_ok_i;
			// Address follows the lines while the latch enable is high
			if (bus_i.ale)
				addr_q <= bus_i.ad;
		end
	end

	// ------------------------------------------------------------------
	// Register A: flags and power-active-bar
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			stat_q <= '0;
		end
		else
		begin
			// Live status bits
			// Battery health is read-only
			stat_q.aux_battery_ok <= aux_battery_supply_i;
			stat_q.update_pending <= upd_q;
			if (wr_stb && hit_a)
			begin
				stat_q.spare <= wstat.spare;
				// Software may set or clear each flag
				// Writing zero removes the interrupt cause
				stat_q.ram_clear_flag <= wstat.ram_clear_flag | clr_done;
				// Only software removes a stale flag
				stat_q.wakeup_flag <= wstat.wakeup_flag | wake_ev;
				stat_q.kickstart_event_flag <=
					wstat.kickstart_event_flag | kick_ev;
			end
			else
			begin
				if (clr_done)
					stat_q.ram_clear_flag <= 1'b1;
				// Events set the flags; an event beats a clear
				if (wake_ev)
					stat_q.wakeup_flag <= 1'b1;
				if (kick_ev)
					stat_q.kickstart_event_flag <= 1'b1;
			end
			// Active enabled wake or kickstart flag forces the bar low
			if (wake_act || kick_act || start_req)
				stat_q.power_active_bar <= 1'b0;
			else if (wr_stb && hit_a)
				stat_q.power_active_bar <= wstat.power_active_bar;
		end
	end

	// ------------------------------------------------------------------
	// Register B
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			ctrl_q <= rpw_ctrl_b_t'(RST_CTRL_B);
		else
		begin
			if (wr_stb && hit_b)
				ctrl_q <= rpw_ctrl_b_t'(bus_i.ad);
			// Supply arrival wins over a write
			if (main_supply_ok_i && !main_prev_q)
				ctrl_q.enable_32k <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Extended RAM
	// ------------------------------------------------------------------
	// Pointer loaded through its own register
	// Data accesses leave the pointer alone
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			xaddr_q <= RST_XRAM_ADDR;
		else if (wr_stb && hit_xa)
			xaddr_q <= bus_i.ad[6:0];
	end

	// The clear walk never touches this array
	always_ff @(posedge clock_i)
	begin
		if (wr_stb && hit_xd)
			xram_q[xaddr_q] <= bus_i.ad;
	end

	// ------------------------------------------------------------------
	// User RAM and clear walk
	// ------------------------------------------------------------------
	// One byte per cycle, all bits set; runs with or without supply
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			clearing_q <= 1'b0;
			clr_idx_q <= 8'h00;
		end
		else if (clr_start)
		begin
			clearing_q <= 1'b1;
			clr_idx_q <= 8'h00;
		end
		else if (clr_done)
			clearing_q <= 1'b0;
		else if (clearing_q)
			clr_idx_q <= clr_idx_q + 8'h01;
	end

	// Host writes cannot collide: the lockout covers the whole walk
	always_ff @(posedge clock_i)
	begin
		if (clearing_q)
			uram_q[clr_idx_q] <= URAM_CLEAR_VAL;
		else if (wr_stb && hit_u)
			uram_q[uidx] <= bus_i.ad;
	end

	// Lockout spans the recovery time from the clear edge
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			rec_q <= 25'd0;
		else if (clr_start)
			rec_q <= 25'(REC_CYCLES);
		else if (rec_q != 25'd0)
			rec_q <= rec_q - 25'd1;
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Unmapped and calendar locations read as zero
	wire [7:0] rmux = hit_a ? stat_q :
		hit_b ? ctrl_q :
		hit_xa ? {1'b0, xaddr_q} :
		hit_xd ? xram_q[xaddr_q] :
		hit_u ? uram_q[uidx] : 8'h00;

	// Read data one cycle behind the strobe; refused reads stay off
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rdata_q <= 8'h00;
			rd_oe_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rmux;
			rd_oe_q <= rd_act;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign ad_o = rdata_q;
	assign ad_oe_o = rd_oe_q;
	assign power_request_n_o = 1'b0;
	assign power_request_n_oe_o = pwr_oe_q;
	assign irq_n_o = 1'b0;
	assign irq_n_oe_o = irq_oe_q;
	assign enable_32k_o = ctrl_q.enable_32k;
	assign crystal_select_o = ctrl_q.crystal_select;

endmodule // rpw_ctrl

// ### bench/rpw_supply_model.sv
// Purpose: System power supply that answers the power request pin
// Assumes: Pin level given with the pull-up already resolved
// Notes: Rise and decay both take DELAY cycles; cut drops it at once
`timescale 1ns/10ps
module rpw_supply_model
#(
	parameter int DELAY = 64
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pwr_n_i,
	input wire logic slow_i,
	input wire logic cut_i,
	output logic supply_ok_o
);
	// Charge level of the supply rail
	int cnt_q;

	// -------------------------------------------------------------
	// Supply rail
	// -------------------------------------------------------------
	// Hysteresis keeps a short request glitch from dropping the rail
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			cnt_q <= DELAY;
			supply_ok_o <= 1'b1;
		end
		else
		begin
			// A slow supply never comes up, so the request times out
			if (cut_i)
				cnt_q <= 0;
			else if (!pwr_n_i && !slow_i && cnt_q < DELAY)
				cnt_q <= cnt_q + 1;
			else if (pwr_n_i && cnt_q > 0)
				cnt_q <= cnt_q - 1;
			if (cnt_q == DELAY)
				supply_ok_o <= 1'b1;
			else if (cnt_q == 0)
				supply_ok_o <= 1'b0;
		end
	end
endmodule // rpw_supply_model

// ### bench/rpw_ctrl_sva.sv
// Purpose: Port-level checks of the power and RAM-clear block
// Assumes: Register B shadow is rebuilt from host writes
// Notes: Writes during clear lockout are not expected
`timescale 1ns/10ps
module rpw_ctrl_sva
	import rpw_pkg::*;
#(
	parameter int unsigned POTO_TICKS = POTO_TICKS_DEF,
	parameter int unsigned REC_CYCLES = REC_CYCLES_DEF
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire rpw_bus_t bus_i,
	input wire logic ad_oe_o,
	input wire logic bank_select_i,
	input wire logic main_supply_ok_i,
	input wire logic alarm_match_i,
	input wire logic power_key_input_n_i,
	input wire logic ram_clear_input_n_i,
	input wire logic power_request_n_oe_o,
	input wire logic irq_n_oe_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// Latched address and write-edge history
	logic [7:0] addr_q;
	logic wr_prev_q;
	rpw_ctrl_b_t ctrl_q;
	wire wr_hit = !bus_i.cs_n && !bus_i.wr_n && wr_prev_q && bank_select_i;
	wire wr_a = wr_hit && addr_q == OFS_EXT_STAT_A;
	wire wr_b = wr_hit && addr_q == OFS_EXT_CTRL_B;

	// -------------------------------------------------------------
	// Shadow of the control register
	// -------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		wr_prev_q <= bus_i.wr_n;
		if (bus_i.ale)
			addr_q <= bus_i.ad;
		if (rst_i)
			ctrl_q <= rpw_ctrl_b_t'(RST_CTRL_B);
		else if (wr_b)
			ctrl_q <= rpw_ctrl_b_t'(bus_i.ad);
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	a_read_window: assert property (
		!(!bus_i.cs_n && !bus_i.rd_n) |=> !ad_oe_o)
		else $error("data driven without a read");
	a_irq_supply: assert property (!main_supply_ok_i |=> !irq_n_oe_o)
		else $error("irq driven without supply");
	a_wake_request: assert property (
		main_supply_ok_i && alarm_match_i && ctrl_q.wakeup_irq_enable
		|-> ##[1:4] power_request_n_oe_o)
		else $error("wake did not drive request");
	a_key_request: assert property (
		main_supply_ok_i && $fell(power_key_input_n_i) &&
		ctrl_q.kickstart_irq_enable |-> ##[1:5] power_request_n_oe_o)
		else $error("key did not drive request");
	a_wake_irq: assert property (
		main_supply_ok_i && alarm_match_i && ctrl_q.wakeup_irq_enable
		|-> ##[1:5] irq_n_oe_o)
		else $error("wake did not drive irq");
	a_clear_lockout: assert property (
		$fell(ram_clear_input_n_i) && ctrl_q.ram_clear_enable
		|-> ##2 (!ad_oe_o) [*8])
		else $error("read answered during lockout");
	a_bar_release: assert property (
		wr_a && bus_i.ad[3] && bus_i.ad[1:0] == 2'b00 && !alarm_match_i
		|-> ##[1:2] !power_request_n_oe_o)
		else $error("request kept after bar set");
	a_bar_drive: assert property (
		wr_a && !bus_i.ad[3] && main_supply_ok_i
		|-> ##[1:2] power_request_n_oe_o)
		else $error("request not driven with bar clear");
endmodule // rpw_ctrl_sva

bind rpw_ctrl rpw_ctrl_sva #(.POTO_TICKS(POTO_TICKS), .REC_CYCLES(REC_CYCLES))
	rpw_ctrl_sva_inst (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i),
	.ad_oe_o(ad_oe_o), .bank_select_i(bank_select_i),
	.main_supply_ok_i(main_supply_ok_i), .alarm_match_i(alarm_match_i),
	.power_key_input_n_i(power_key_input_n_i),
	.ram_clear_input_n_i(ram_clear_input_n_i),
	.power_request_n_oe_o(power_request_n_oe_o), .irq_n_oe_o(irq_n_oe_o));

// ### bench/testbench.sv
// Purpose: Self-checking bench for the power and RAM-clear block
// Assumes: Supply model answers the power request pin
// Notes: Short timeout and recovery counts keep the run brief
`timescale 1ns/10ps
module testbench;
	import rpw_pkg::*;
	localparam int unsigned POTO = 8;
	localparam int unsigned REC = 300;
	// Watchdog: two full timeouts plus slack
	localparam int unsigned WD = (POTO + 4) * TB_DIV * 2;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	rpw_bus_t bus = '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
	logic bank = 1'b1;
	logic [2:0] div = 3'b010;
	logic aux = 1'b1;
	logic alarm = 1'b0;
	logic other = 1'b0;
	logic key_n = 1'b1;
	logic clr_n = 1'b1;
	logic slow = 1'b0;
	logic cut = 1'b0;
	logic sup, ad_oe, preq_n, preq_oe, irq_n, irq_oe, oe, e32k, xtal;
	logic [7:0] ad_o, rv;
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	logic [31:0] seed = 32'h00014055;
	logic [7:0] xmem [128];
	logic [6:0] xa [8];
	// Open-drain request line with its pull-up
	wire pwr_line = preq_oe ? preq_n : 1'b1;

	rpw_ctrl #(.POTO_TICKS(POTO), .REC_CYCLES(REC)) rpw_ctrl_inst (
		.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus), .ad_o(ad_o),
		.ad_oe_o(ad_oe), .bank_select_i(bank), .divider_bits_i(div),
		.main_supply_ok_i(sup), .aux_battery_supply_i(aux),
		.alarm_match_i(alarm), .other_irq_i(other),
		.power_key_input_n_i(key_n), .ram_clear_input_n_i(clr_n),
		.power_request_n_o(preq_n), .power_request_n_oe_o(preq_oe),
		.irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .enable_32k_o(e32k),
		.crystal_select_o(xtal));
	rpw_supply_model rpw_supply_model_inst (.clock_i(clock_i),
		.rst_i(rst_i), .pwr_n_i(pwr_line), .slow_i(slow), .cut_i(cut),
		.supply_ok_o(sup));

	initial
	begin
		forever #4 clock_i = ~clock_i;
	end

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge clock_i);
		#1;
	endtask

	// Address phase, then one write strobe; idle bus shows inverse data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i) bus <= '{1'b1, 1'b1, 1'b1, 1'b1, a};
		@(posedge clock_i) bus <= '{1'b0, 1'b0, 1'b1, 1'b0, d};
		@(posedge clock_i) bus <= '{1'b0, 1'b1, 1'b1, 1'b1, ~d};
	endtask

	// Data is taken one cycle after the strobe is seen
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic e);
		@(posedge clock_i) bus <= '{1'b1, 1'b1, 1'b1, 1'b1, a};
		@(posedge clock_i) bus <= '{1'b0, 1'b0, 1'b0, 1'b1, ~a};
		wt(1);
		d = ad_o;
		e = ad_oe;
		@(posedge clock_i) bus <= '{1'b0, 1'b1, 1'b1, 1'b1, a};
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		rd(a, rv, oe);
		check({7'h00, oe}, 8'h01);
		check(rv, exp);
	endtask

	task automatic close_out;
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (WD) @(posedge clock_i);
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out;
	end

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		wt(3);
		check({7'h00, preq_oe}, 8'h01);
		chk_rd(OFS_EXT_STAT_A, 8'h80);
		@(posedge clock_i) aux <= 1'b0;
		chk_rd(OFS_EXT_STAT_A, 8'h00);
		@(posedge clock_i) aux <= 1'b1;
		// Software release and re-drive of the request
		wr(OFS_EXT_STAT_A, 8'h08);
		wt(2);
		check({7'h00, preq_oe}, 8'h00);
		chk_rd(OFS_EXT_STAT_A, 8'h88);
		wr(OFS_EXT_STAT_A, 8'h00);
		wt(2);
		check({7'h00, preq_oe}, 8'h01);
		// Powered wake event overrides the bar bit
		wr(OFS_EXT_STAT_A, 8'h08);
		wr(OFS_EXT_CTRL_B, 8'h02);
		@(posedge clock_i) alarm <= 1'b1;
		@(posedge clock_i) alarm <= 1'b0;
		wt(4);
		check({6'h00, preq_oe, irq_oe}, 8'h03);
		chk_rd(OFS_EXT_STAT_A, 8'h82);
		@(posedge clock_i) other <= 1'b1;
		wr(OFS_EXT_STAT_A, 8'h00);
		wt(2);
		check({7'h00, irq_oe}, 8'h01);
		@(posedge clock_i) other <= 1'b0;
		wt(2);
		check({7'h00, irq_oe}, 8'h00);
		// Disabled enable: the flag is set but moves no pin
		wr(OFS_EXT_STAT_A, 8'h08);
		wr(OFS_EXT_CTRL_B, 8'h00);
		@(posedge clock_i) alarm <= 1'b1;
		@(posedge clock_i) alarm <= 1'b0;
		wt(4);
		check({6'h00, preq_oe, irq_oe}, 8'h00);
		chk_rd(OFS_EXT_STAT_A, 8'h8A);
		wr(OFS_EXT_STAT_A, 8'h00);
		// Key fall, then a software-set clear flag
		wr(OFS_EXT_CTRL_B, 8'h05);
		@(posedge clock_i) key_n <= 1'b0;
		wt(4);
		check({7'h00, irq_oe}, 8'h01);
		chk_rd(OFS_EXT_STAT_A, 8'h81);
		@(posedge clock_i) key_n <= 1'b1;
		wr(OFS_EXT_STAT_A, 8'h34);
		chk_rd(OFS_EXT_STAT_A, 8'hB4);
		check({7'h00, irq_oe}, 8'h01);
		wr(OFS_EXT_STAT_A, 8'h00);
		wt(2);
		check({7'h00, irq_oe}, 8'h00);
		// Supply cut with hold select set; a pending irq must drop
		wr(OFS_EXT_CTRL_B, 8'h08);
		@(posedge clock_i);
		cut <= 1'b1;
		other <= 1'b1;
		wt(4);
		check({6'h00, preq_oe, irq_oe}, 8'h02);
		@(posedge clock_i);
		cut <= 1'b0;
		other <= 1'b0;
		for (n = 0; n < 300 && sup !== 1'b1; n++) wt(1);
		// Prepare a key wake-up, then power off under software
		wr(OFS_EXT_STAT_A, 8'h00);
		wr(OFS_EXT_CTRL_B, 8'h81);
		@(posedge clock_i) slow <= 1'b1;
		wr(OFS_EXT_STAT_A, 8'h08);
		for (n = 0; n < 300 && sup !== 1'b0; n++) wt(1);
		check({6'h00, sup, irq_oe}, 8'h00);
		// Divider chain held: a battery-mode key press is ignored
		@(posedge clock_i) div <= 3'b000;
		@(posedge clock_i) key_n <= 1'b0;
		wt(4);
		check({7'h00, preq_oe}, 8'h00);
		@(posedge clock_i) key_n <= 1'b1;
		@(posedge clock_i) div <= 3'b010;
		@(posedge clock_i) key_n <= 1'b0;
		wt(4);
		check({7'h00, preq_oe}, 8'h01);
		@(posedge clock_i) key_n <= 1'b1;
		// Supply never comes: request released after the timeout
		for (n = 0; n < 40000 && preq_oe === 1'b1; n++) wt(1);
		check({7'h00, n >= (POTO - 1) * TB_DIV &&
			n <= (POTO + 1) * TB_DIV}, 8'h01);
		check({7'h00, irq_oe}, 8'h00);
		chk_rd(OFS_EXT_STAT_A, 8'h81);
		// Same request with a supply that answers in time
		wr(OFS_EXT_STAT_A, 8'h08);
		@(posedge clock_i) slow <= 1'b0;
		@(posedge clock_i) key_n <= 1'b0;
		for (n = 0; n < 300 && irq_oe !== 1'b1; n++) wt(1);
		check({6'h00, preq_oe, irq_oe}, 8'h03);
		@(posedge clock_i) key_n <= 1'b1;
		wr(OFS_EXT_STAT_A, 8'h00);
		// Enabled RAM clear: lockout, user RAM set, extended RAM kept
		wr(8'h20, 8'h5A);
		wr(OFS_XRAM_ADDR, 8'h05);
		wr(OFS_XRAM_DATA, 8'hA5);
		wr(OFS_EXT_CTRL_B, 8'h14);
		@(posedge clock_i) clr_n <= 1'b0;
		rd(OFS_EXT_CTRL_B, rv, oe);
		check({7'h00, oe}, 8'h00);
		wt(REC + 20);
		@(posedge clock_i) clr_n <= 1'b1;
		chk_rd(8'h20, URAM_CLEAR_VAL);
		chk_rd(OFS_URAM_LO, URAM_CLEAR_VAL);
		chk_rd(8'hFF, URAM_CLEAR_VAL);
		chk_rd(OFS_XRAM_DATA, 8'hA5);
		chk_rd(OFS_EXT_STAT_A, 8'h84);
		check({7'h00, irq_oe}, 8'h01);
		// Clear enable low: pin has no effect
		wr(OFS_EXT_STAT_A, 8'h00);
		wr(OFS_EXT_CTRL_B, 8'h04);
		wr(8'h20, 8'h33);
		@(posedge clock_i) clr_n <= 1'b0;
		wt(REC + 20);
		@(posedge clock_i) clr_n <= 1'b1;
		chk_rd(8'h20, 8'h33);
		chk_rd(OFS_EXT_STAT_A, 8'h80);
		// Bank zero hides the extended registers
		@(posedge clock_i) bank <= 1'b0;
		wr(OFS_EXT_CTRL_B, 8'h7C);
		chk_rd(OFS_EXT_CTRL_B, 8'h7C);
		check({4'h0, e32k, xtal, preq_n, irq_n}, 8'h00);
		chk_rd(8'h05, 8'h00);
		@(posedge clock_i) bank <= 1'b1;
		chk_rd(OFS_EXT_CTRL_B, 8'h04);
		// Random extended RAM traffic, top location included
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			xa[i] = (i == 0) ? 7'h7F : seed[6:0];
			xmem[xa[i]] = seed[15:8];
			wr(OFS_XRAM_ADDR, {1'b0, xa[i]});
			wr(OFS_XRAM_DATA, seed[15:8]);
		end
		for (int i = 7; i >= 0; i--)
		begin
			wr(OFS_XRAM_ADDR, {1'b0, xa[i]});
			chk_rd(OFS_XRAM_DATA, xmem[xa[i]]);
			chk_rd(OFS_XRAM_DATA, xmem[xa[i]]);
		end
		chk_rd(OFS_XRAM_ADDR, {1'b0, xa[0]});
		close_out;
	end
endmodule // testbench
